/* File: hw/pstfc_top.v */
// Notes on behaviour
// - program words are 24 bits, data words 16 bits, alignment kept both ways
// - table address is page select in 23:16 and effective address in 15:0
// - address bit 23 low selects user memory, high selects configuration space
// - program counter steps by two per word, bit 0 always zero
// - low read, word mode: program bits 15:0 returned unchanged
// - low read, byte mode: byte select one gives upper byte, zero lower byte
// - high read, word mode: bits 23:16 in data 7:0, data 15:8 zero
// - high read, byte mode: select zero gives bits 23:16, select one gives zero
// - low writes hit bits 15:0, word or byte; high writes hit bits 23:16 in word mode or byte mode with select zero
// - window into data space is read only, lower 16 bits only
// - erase covers a whole page of 1024 words, 3072 bytes
// - program writes two adjacent 24-bit words at a double-word boundary
// - setting start bit launches the operation, hardware clears it at the end; a go pulse landing in S_TRD or S_WRD is lost, start bit left set
// - processor is stalled while an erase or program runs
// - key must see 0x55 then 0xAA back to back before a start
// - key register is write only and only guards the start
// - upper and lower address registers form the 24-bit target address
// - double-word program is aligned to the four-unit word pair boundary
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pstfc_map.vh"
module pstfc_top #(
  parameter [15:0] ERASE_CYC = `PSTFC_ERASE_CYC,
  parameter [15:0] PROG_CYC  = `PSTFC_PROG_CYC
) (
  input  wire        hclk,           // system clock
  input  wire        hresetn,        // async reset, active low
  input  wire        hsel,           // slave select
  input  wire [31:0] haddr,          // byte address
  input  wire [1:0]  htrans,         // transfer type
  input  wire        hwrite,         // write transfer
  input  wire [2:0]  hsize,          // transfer size, word only
  input  wire [31:0] hwdata,         // write data
  input  wire        hready,         // bus ready
  output reg         hreadyout,      // slave ready
  output reg  [31:0] hrdata,         // read data
  output reg         hresp,          // always okay
  input  wire        pc_step,        // advance to next program word
  input  wire        pc_load,        // load program counter
  input  wire [23:0] pc_load_val,    // value to load
  output reg  [23:0] pc,             // program counter
  input  wire        tbl_req,        // table operation request
  input  wire        tbl_write,      // table write, else read
  input  wire        tbl_high,       // high word access, else low
  input  wire        tbl_byte,       // byte mode, else word
  input  wire [15:0] tbl_ea,         // effective address
  input  wire [15:0] tbl_wdata,      // table write data
  output reg  [15:0] tbl_rdata,      // table read data
  output reg         tbl_done,       // table operation done pulse
  input  wire        win_req,        // window read request
  input  wire [15:0] win_ea,         // window effective address
  output reg  [15:0] win_rdata,      // window read data
  output reg         win_done,       // window read done pulse
  output reg         core_stall,     // stall processor
  output reg  [23:0] fl_addr,        // flash address
  output reg         fl_rd,          // flash read strobe
  output reg         fl_prog,        // flash double-word program strobe
  output reg         fl_erase,       // flash page erase strobe
  output reg         fl_cfg,         // configuration space select
  output reg  [47:0] fl_wdata,       // two program words, upper word high
  input  wire [23:0] fl_rdata        // flash read data
);

  // idle, table read, window read, erase or program in progress
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_TRD  = 2'd1;
  localparam [1:0] S_WRD  = 2'd2;
  localparam [1:0] S_OP   = 2'd3;

  reg  [1:0]  state;
  reg  [15:0] op_cnt;
  reg         op_finish;
  reg         go;
  reg         wr;
  reg         wren;
  reg         wrerr;
  reg  [3:0]  op_sel;
  reg  [7:0]  adru;
  reg  [15:0] adrl;
  reg  [7:0]  page_sel;
  reg  [7:0]  win_page;
  reg         key_stage;
  reg         unlocked;
  reg         a_wr;
  reg         a_rd;
  reg  [7:0]  a_addr;
  reg         r_high;
  reg         r_byte;
  reg         r_bsel;
  reg  [23:0] wlat [0:1];
  wire        take;
  wire        op_valid;
  wire        start_req;
  reg  [31:0] rd_mux;

  // hsize is not decoded: only whole-word transfers are expected
  assign take      = hsel & htrans[1] & hready;
  assign op_valid  = (op_sel == `PSTFC_OP_PROG) | (op_sel == `PSTFC_OP_ERASE);
  // a start only counts while no operation runs, so a second start cannot stack
  assign start_req = a_wr & (a_addr == `PSTFC_OFF_CTRL) & hwdata[`PSTFC_WR_BIT] & ~wr;

  // key has no read path
  always @*
  begin
    // unmapped offsets read as zero
    rd_mux = 32'h0;
    if (a_addr == `PSTFC_OFF_CTRL)
      rd_mux = {16'h0, wr, wren, wrerr, 9'h0, op_sel};
    else if (a_addr == `PSTFC_OFF_ADRU)
      rd_mux = {24'h0, adru};
    else if (a_addr == `PSTFC_OFF_ADRL)
      rd_mux = {16'h0, adrl};
    else if (a_addr == `PSTFC_OFF_PAGE)
      rd_mux = {24'h0, page_sel};
    else if (a_addr == `PSTFC_OFF_WPAGE)
      rd_mux = {24'h0, win_page};
  end

  // reads take one wait state so a write just before is already visible
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
      // never raised: every transfer ends with an okay response
      hresp     <= 1'b0;
      a_wr      <= 1'b0;
      a_rd      <= 1'b0;
      a_addr    <= 8'h0;
    end
    else
    begin
      a_wr <= 1'b0;
      if (a_rd)
      begin
        hrdata    <= rd_mux;
        hreadyout <= 1'b1;
        a_rd      <= 1'b0;
      end
      else if (take)
      begin
        a_addr <= {haddr[7:2], 2'b00};
        a_wr   <= hwrite;
        a_rd   <= ~hwrite;
        if (!hwrite)
          hreadyout <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr        <= 1'b0;
      wren      <= 1'b0;
      wrerr     <= 1'b0;
      op_sel    <= 4'h0;
      adru      <= `PSTFC_ADDR_RST;
      adrl      <= {`PSTFC_ADDR_RST, `PSTFC_ADDR_RST};
      page_sel  <= `PSTFC_ADDR_RST;
      win_page  <= `PSTFC_ADDR_RST;
      key_stage <= 1'b0;
      unlocked  <= 1'b0;
      go        <= 1'b0;
    end
    else
    begin
      go <= 1'b0;
      if (op_finish)
        wr <= 1'b0;
      if (a_wr)
      begin
        // any other write between the two key values breaks the sequence
        key_stage <= 1'b0;
        if (a_addr == `PSTFC_OFF_KEY)
        begin
          if (hwdata[7:0] == `PSTFC_KEY_FIRST)
            key_stage <= 1'b1;
          else if (key_stage && hwdata[7:0] == `PSTFC_KEY_SECOND)
            unlocked <= 1'b1;
        end
        else if (a_addr == `PSTFC_OFF_CTRL)
        begin
          wren  <= hwdata[`PSTFC_WREN_BIT];
          wrerr <= hwdata[`PSTFC_WRERR_BIT];
          if (!wr)
            op_sel <= hwdata[`PSTFC_OP_MSB:`PSTFC_OP_LSB];
          // enable and operation select must already hold their values when the start
          // bit arrives; setting them in the same write is refused with the error flag
          if (start_req)
          begin
            unlocked <= 1'b0;
            if (wren && unlocked && op_valid)
            begin
              wr <= 1'b1;
              go <= 1'b1;
            end
            else
              wrerr <= 1'b1;
          end
        end
        else if (a_addr == `PSTFC_OFF_ADRU)
          adru <= hwdata[7:0];
        else if (a_addr == `PSTFC_OFF_ADRL)
          adrl <= hwdata[15:0];
        else if (a_addr == `PSTFC_OFF_PAGE)
          page_sel <= hwdata[7:0];
        else if (a_addr == `PSTFC_OFF_WPAGE)
          win_page <= hwdata[7:0];
      end
    end
  end

  // a load wins over a step; steps are held off while the core is stalled
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pc <= 24'h0;
    else if (pc_load)
      pc <= {pc_load_val[23:1], 1'b0};
    else if (pc_step && !core_stall)
      pc <= pc + `PSTFC_PC_STEP;
  end

  // write latches: one per word of the pair, selected by address bit 1
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_lat
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          wlat[gi] <= `PSTFC_LATCH_RST;
        else if (state == S_IDLE && !go && tbl_req && tbl_write && tbl_ea[1] == (gi == 1))
        begin
          if (!tbl_high && !tbl_byte)
            wlat[gi][15:0] <= tbl_wdata;
          else if (!tbl_high && tbl_ea[0])
            wlat[gi][15:8] <= tbl_wdata[7:0];
          else if (!tbl_high)
            wlat[gi][7:0] <= tbl_wdata[7:0];
          // a byte write aimed at the phantom byte is dropped
          else if (!tbl_byte || !tbl_ea[0])
            wlat[gi][23:16] <= tbl_wdata[7:0];
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= S_IDLE;
      op_cnt     <= 16'h0;
      op_finish  <= 1'b0;
      core_stall <= 1'b0;
      fl_addr    <= 24'h0;
      fl_rd      <= 1'b0;
      fl_prog    <= 1'b0;
      fl_erase   <= 1'b0;
      fl_cfg     <= 1'b0;
      fl_wdata   <= 48'h0;
      tbl_rdata  <= 16'h0;
      tbl_done   <= 1'b0;
      win_rdata  <= 16'h0;
      win_done   <= 1'b0;
      r_high     <= 1'b0;
      r_byte     <= 1'b0;
      r_bsel     <= 1'b0;
    end
    else
    begin
      fl_rd     <= 1'b0;
      fl_prog   <= 1'b0;
      fl_erase  <= 1'b0;
      tbl_done  <= 1'b0;
      win_done  <= 1'b0;
      op_finish <= 1'b0;
      case (state)
        // priority in idle: start, then table, then window
        S_IDLE:
        begin
          if (go)
          begin
            state      <= S_OP;
            core_stall <= 1'b1;
            fl_cfg     <= adru[7];
            if (op_sel == `PSTFC_OP_ERASE)
            begin
              fl_erase <= 1'b1;
              fl_addr  <= {adru, adrl[15:11], `PSTFC_PAGE_LSBS};
              op_cnt   <= ERASE_CYC;
            end
            else
            begin
              fl_prog  <= 1'b1;
              fl_addr  <= {adru, adrl[15:2], `PSTFC_DWORD_LSBS};
              fl_wdata <= {wlat[1], wlat[0]};
              op_cnt   <= PROG_CYC;
            end
          end
          else if (tbl_req && tbl_write)
            tbl_done <= 1'b1;
          else if (tbl_req)
          begin
            fl_addr <= {page_sel, tbl_ea};
            fl_cfg  <= page_sel[7];
            fl_rd   <= 1'b1;
            r_high  <= tbl_high;
            r_byte  <= tbl_byte;
            r_bsel  <= tbl_ea[0];
            state   <= S_TRD;
          end
          else if (win_req)
          begin
            // the window has no write path at all
            fl_addr <= {win_page, win_ea[15:1], 1'b0};
            fl_cfg  <= win_page[7];
            fl_rd   <= 1'b1;
            state   <= S_WRD;
          end
        end
        // flash data is taken at the edge that ends the read strobe
        S_TRD:
        begin
          tbl_done <= 1'b1;
          state    <= S_IDLE;
          if (!r_high && !r_byte)
            tbl_rdata <= fl_rdata[15:0];
          else if (!r_high && r_bsel)
            tbl_rdata <= {8'h00, fl_rdata[15:8]};
          else if (!r_high)
            tbl_rdata <= {8'h00, fl_rdata[7:0]};
          else if (!r_byte)
            tbl_rdata <= {8'h00, fl_rdata[23:16]};
          else if (r_bsel)
            tbl_rdata <= 16'h0000;
          else
            tbl_rdata <= {8'h00, fl_rdata[23:16]};
        end
        S_WRD:
        begin
          win_rdata <= fl_rdata[15:0];
          win_done  <= 1'b1;
          state     <= S_IDLE;
        end
        S_OP:
        begin
          // page must already be erased before a program; not checked here
          // the counter is loaded at launch, so the stall lasts the parameter count
          if (op_cnt <= 16'h0001)
          begin
            op_finish  <= 1'b1;
            core_stall <= 1'b0;
            state      <= S_IDLE;
          end
          else
            op_cnt <= op_cnt - 16'h0001;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

endmodule

/* File: pkg/pstfc_map.vh */
`ifndef PSTFC_MAP_VH
`define PSTFC_MAP_VH
// register byte offsets (haddr[7:0])
`define PSTFC_OFF_CTRL      8'h00
`define PSTFC_OFF_KEY       8'h04
`define PSTFC_OFF_ADRU      8'h08
`define PSTFC_OFF_ADRL      8'h0c
`define PSTFC_OFF_PAGE      8'h10
`define PSTFC_OFF_WPAGE     8'h14
// control register fields
`define PSTFC_WR_BIT        15
`define PSTFC_WREN_BIT      14
`define PSTFC_WRERR_BIT     13
`define PSTFC_OP_MSB        3
`define PSTFC_OP_LSB        0
// operation select codes
`define PSTFC_OP_PROG       4'h1
`define PSTFC_OP_ERASE      4'h3
// unlock key values
`define PSTFC_KEY_FIRST     8'h55
`define PSTFC_KEY_SECOND    8'haa
// address alignment
`define PSTFC_CFG_BIT       23
`define PSTFC_DWORD_LSBS    2'h0
`define PSTFC_PAGE_LSBS     11'h000
`define PSTFC_PAGE_WORDS    1024
`define PSTFC_PAGE_BYTES    3072
`define PSTFC_PC_STEP       24'h000002
// reset values
`define PSTFC_LATCH_RST     24'hffffff
`define PSTFC_ADDR_RST      8'h00
// timing defaults in cycles
`define PSTFC_ERASE_CYC     16'd2000
`define PSTFC_PROG_CYC      16'd400
`endif

/* File: dv/pstfc_props.sv */
`timescale 1ns/1ps
module pstfc_props #(
  parameter [15:0] ERASE_CYC = 16'd2000,
  parameter [15:0] PROG_CYC  = 16'd400
) (
  input wire logic        hclk,        // clock
  input wire logic        hresetn,     // reset, active low
  input wire logic        pc_step,     // step
  input wire logic        pc_load,     // load
  input wire logic [23:0] pc,          // counter
  input wire logic        core_stall,  // stall
  input wire logic [23:0] fl_addr,     // flash address
  input wire logic        fl_rd,       // read strobe
  input wire logic        fl_prog,     // program strobe
  input wire logic        fl_erase,    // erase strobe
  input wire logic        fl_cfg,      // config select
  input wire logic        tbl_write,   // table write
  input wire logic        tbl_high,    // high word
  input wire logic        tbl_byte,    // byte mode
  input wire logic [15:0] tbl_ea,      // effective address
  input wire logic [15:0] tbl_rdata,   // table data
  input wire logic        tbl_done     // table done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // stall length bounded by the longer of the two operation times
  localparam [15:0] LONG_CYC = (ERASE_CYC > PROG_CYC) ? ERASE_CYC : PROG_CYC;
  logic [15:0] scnt;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      scnt <= 16'h0;
    else
      scnt <= core_stall ? scnt + 16'h1 : 16'h0;
  property p_pc_even; pc[0] == 1'b0; endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc bit 0 set");
  property p_pc_step; pc_step && !pc_load && !core_stall |=> pc == $past(pc) + 24'h2; endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  property p_erase; fl_erase |-> fl_addr[10:0] == 11'h0 && core_stall; endproperty
  a_erase: assert property (p_erase) else $error("erase not page aligned");
  property p_prog; fl_prog |-> fl_addr[1:0] == 2'h0 && core_stall; endproperty
  a_prog: assert property (p_prog) else $error("program not pair aligned");
  property p_cfg; fl_rd |-> fl_cfg == fl_addr[23]; endproperty
  a_cfg: assert property (p_cfg) else $error("space select wrong");
  property p_stall_len; scnt <= LONG_CYC + 16'h1; endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall too long");
  property p_hi_word;
    tbl_done && !tbl_write && tbl_high && !tbl_byte |-> tbl_rdata[15:8] == 8'h0;
  endproperty
  a_hi_word: assert property (p_hi_word) else $error("high byte not zero");
  property p_hi_ph;
    tbl_done && !tbl_write && tbl_high && tbl_byte && tbl_ea[0] |-> tbl_rdata == 16'h0;
  endproperty
  a_hi_ph: assert property (p_hi_ph) else $error("phantom byte not zero");
  c_prog: cover property (fl_prog);
  c_erase: cover property (fl_erase);
  c_ph: cover property (tbl_done && tbl_high && tbl_byte);
endmodule
bind pstfc_top pstfc_props #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) pstfc_props_inst (
  .hclk, .hresetn, .pc_step, .pc_load, .pc, .core_stall, .fl_addr, .fl_rd, .fl_prog, .fl_erase,
  .fl_cfg, .tbl_write, .tbl_high, .tbl_byte, .tbl_ea, .tbl_rdata, .tbl_done);

/* File: dv/pstfc_flash_model.sv */
`timescale 1ns/1ps
module pstfc_flash_model (
  input  wire logic [23:0] fl_addr,   // word address
  input  wire logic        fl_rd,     // read strobe
  output logic      [23:0] fl_rdata   // read word
);
  // contents are a fixed function of the address so the bench can predict them
  wire logic [23:0] w = {fl_addr[7:0] ^ 8'ha5, fl_addr[15:0] ^ 16'h1234};
  // outside a read the port shows the inverse, never a stale word
  assign fl_rdata = fl_rd ? w : ~w;
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pc_step, pc_load, tbl_req;
  logic tbl_write, tbl_high, tbl_byte, tbl_done, win_req, win_done, core_stall;
  logic fl_rd, fl_prog, fl_erase, fl_cfg;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [23:0] pc_load_val, pc, fl_addr, fl_rdata, fa, wm;
  logic [15:0] tbl_ea, tbl_wdata, tbl_rdata, win_ea, win_rdata, e;
  logic [47:0] fl_wdata, fd;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  int          errors, n_tests, ns;
  assign hready = hreadyout;
  pstfc_top #(.ERASE_CYC(16'd4), .PROG_CYC(16'd4)) pstfc_top_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pc_step,
    .pc_load, .pc_load_val, .pc, .tbl_req, .tbl_write, .tbl_high, .tbl_byte, .tbl_ea, .tbl_wdata,
    .tbl_rdata, .tbl_done, .win_req, .win_ea, .win_rdata, .win_done, .core_stall, .fl_addr,
    .fl_rd, .fl_prog, .fl_erase, .fl_cfg, .fl_wdata, .fl_rdata);
  pstfc_flash_model pstfc_flash_model_inst (.fl_addr, .fl_rd, .fl_rdata);
  function automatic logic [23:0] fm(input logic [23:0] a);
    return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h1234};
  endfunction
  task automatic ck(input string n, input logic [47:0] x, input logic [47:0] s);
    n_tests++;
    if (s !== x)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic br(input logic [7:0] a);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic tq(input logic w, hi, by, input logic [15:0] ea, wd);
    tbl_write <= w;
    tbl_high <= hi;
    tbl_byte <= by;
    tbl_ea <= ea;
    tbl_wdata <= wd;
    tbl_req <= 1'b1;
    @(posedge hclk);
    tbl_req <= 1'b0;
    repeat (8) if (tbl_done !== 1'b1)
    begin
      @(posedge hclk);
      if (fl_rd === 1'b1) fa = fl_addr;
    end
  endtask
  task automatic t_regs();
    bw(8'h08, 32'h1ff);
    bw(8'h0c, 32'hffff1236);
    bw(8'h04, 32'h12);
    bw(8'h20, 32'h5);
    br(8'h08);
    ck("adru", 32'hff, rd);
    br(8'h0c);
    ck("adrl", 32'h1236, rd);
    br(8'h04);
    ck("key", 0, rd);
    br(8'h20);
    ck("unmapped", 0, rd);
    ck("hresp", 1'b0, hresp);
    bw(8'h08, 32'h2);
    $display("test regs done");
  endtask
  task automatic t_table();
    logic [23:0] a;
    for (int i = 0; i < 16; i++)
    begin
      a = {i[3] ? 8'h80 : 8'h01, 15'h1234, i[0]};
      bw(8'h10, {24'h0, a[23:16]});
      wm = fm(a);
      tq(1'b0, i[2], i[1], a[15:0], 16'h0);
      e = i[2] ? (i[1] && i[0] ? 16'h0 : {8'h0, wm[23:16]})
        : (!i[1] ? wm[15:0] : {8'h0, i[0] ? wm[15:8] : wm[7:0]});
      ck("tbl_rdata", e, tbl_rdata);
      ck("tbl_addr", a, fa);
    end
    $display("test table done");
  endtask
  task automatic op_run(input int k, input logic [3:0] op, input logic [23:0] ea);
    logic ok;
    ok = (k == 1) && (op == 4'h1 || op == 4'h3);
    ns = 0;
    // enable and operation select go in first; the start write only adds the start bit
    bw(8'h00, {16'h0, 12'h400, op});
    if (k > 0) bw(8'h04, 32'h55);
    if (k == 2) bw(8'h08, 32'h2);
    if (k > 0) bw(8'h04, 32'haa);
    bw(8'h00, {16'h0, 12'hc00, op});
    repeat (40)
    begin
      @(posedge hclk);
      if (fl_prog === 1'b1 || fl_erase === 1'b1)
      begin
        ns++;
        fa = fl_addr;
        fd = fl_wdata;
        ck("stall", 1, core_stall);
        ck("kind", op == 4'h1, fl_prog);
      end
    end
    ck("strobes", ok, ns);
    if (ok) ck("fl_addr", ea, fa);
    br(8'h00);
    ck("ctl", {1'b0, !ok}, {rd[15], rd[13]});
    $display("test op %0d %0d done", k, op);
  endtask
  task automatic t_pc();
    pc_load_val <= 24'h000101;
    pc_load <= 1'b1;
    @(posedge hclk);
    pc_load <= 1'b0;
    pc_step <= 1'b1;
    repeat (3) @(posedge hclk);
    pc_step <= 1'b0;
    @(posedge hclk);
    ck("pc", 24'h000106, pc);
    $display("test pc done");
  endtask
  task automatic t_win();
    bw(8'h14, 32'h3);
    win_ea <= 16'h0457;
    win_req <= 1'b1;
    @(posedge hclk);
    win_req <= 1'b0;
    repeat (8) if (win_done !== 1'b1)
    begin
      @(posedge hclk);
      if (fl_rd === 1'b1) fa = fl_addr;
    end
    wm = fm(24'h030456);
    ck("win_addr", 24'h030456, fa);
    ck("win_rdata", wm[15:0], win_rdata);
    $display("test window done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial
  begin
    // the whole run needs a few hundred cycles; allow ten thousand
    #200000;
    errors++;
    final_report();
  end
  initial
  begin
    {hresetn, hwrite, pc_step, pc_load, tbl_req, tbl_write, tbl_high, tbl_byte, win_req} = '0;
    {haddr, hwdata, pc_load_val, tbl_ea, tbl_wdata, win_ea, htrans} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_table();
    t_pc();
    t_win();
    tq(1'b1, 1'b0, 1'b0, 16'h0000, 16'hbeef);
    tq(1'b1, 1'b1, 1'b0, 16'h0000, 16'h0012);
    tq(1'b1, 1'b0, 1'b0, 16'h0002, 16'h4321);
    tq(1'b1, 1'b1, 1'b1, 16'h0002, 16'h00cd);
    op_run(1, 4'h3, 24'h021000);
    op_run(1, 4'h1, 24'h021234);
    ck("fl_wdata", 48'hcd4321_12beef, fd);
    op_run(0, 4'h1, 24'h0);
    op_run(2, 4'h3, 24'h0);
    op_run(1, 4'h2, 24'h0);
    final_report();
  end
endmodule
